// *** src/fisr_cfg.svh ***
// Register offsets, bit positions and reset values of the fault status block
`ifndef FISR_CFG_SVH
`define FISR_CFG_SVH
`define FISR_ADDR_CLK_LATCH 8'h34
`define FISR_ADDR_HS_LATCH 8'h3A
`define FISR_ADDR_MON_LATCH 8'h3B
`define FISR_ADDR_CLK_LIVE 8'h3C
`define FISR_ADDR_CH_LIVE 8'h3D
`define FISR_ADDR_OUT1_LIVE 8'h40
`define FISR_ADDR_OUT2_LIVE 8'h41
`define FISR_ADDR_HS_LIVE 8'h42
`define FISR_RESET_VAL 8'h00
`define FISR_BIT_HS_INSERT 3
`define FISR_BIT_HS_REMOVE 2
`define FISR_BIT_HS_HOOK 1
`define FISR_BIT_THRESH_HIGH 7
`define FISR_BIT_THRESH_LOW 6
`define FISR_BIT_VOICE_UP 5
`define FISR_BIT_VOICE_DOWN 4
`define FISR_BIT_CLK_ERR 7
`define FISR_BIT_PLL_LOCK 6
`define FISR_BIT_IN1 7
`define FISR_BIT_IN2 6
`define FISR_BIT_OUT1 5
`define FISR_BIT_OUT2 4
`define FISR_BIT_SC_P 7
`define FISR_BIT_SC_M 6
`define FISR_BIT_VG_P 5
`define FISR_BIT_VG_M 4
`define FISR_BIT_REG_SHORT 0
`endif

// *** src/fisr_pkg.sv ***
// Types shared by the fault status block
package fisr_pkg;
    typedef logic [7:0] fisr_byte_t;
    typedef logic [7:0] fisr_addr_t;
endpackage

// *** src/fisr_status.sv ***
// Latched and live interrupt and fault status readback registers
// Summary of operation
// - Headset insert latches bit 3 of 0x3A
// - Headset removal latches self-clearing bit 2
// - Hook button latches self-clearing bit 1
// - Analog upper threshold latches bit 7 0x3B
// - Analog lower threshold latches bit 6
// - Voice power-up detect latches bit 5
// - Voice power-down detect latches bit 4
// - Clock error live at bit 7 0x3C
// - PLL lock live at bit 6
// - Input channel 1 fault summary bit 7
// - Input channel 2 fault summary bit 6
// - Output channel faults bits 5 and 4
// - Output 1 shorts in bits 7, 6
// - Output 1 virtual ground bits 5, 4
// - Output 2 shorts in bits 7, 6
// - Output 2 virtual ground bits 5, 4
// - Regulator short live at bit 0
// - Reserved bits read zero; write reset
// - Latched clock error at bit 7, self-clearing
`timescale 1ns/1ps
`include "fisr_cfg.svh"

module fisr_status (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register read port
    input wire logic rd_en,
    input wire fisr_pkg::fisr_addr_t rd_addr,
    output fisr_pkg::fisr_byte_t rd_data,
    // Latched event sources, level high while detected
    input wire logic hs_insert,
    input wire logic hs_remove,
    input wire logic hs_hook,
    input wire logic thresh_high,
    input wire logic thresh_low,
    input wire logic voice_up,
    input wire logic voice_down,
    // Live clock conditions
    input wire logic clk_err,
    input wire logic pll_lock,
    // Channel fault conditions
    input wire logic in1_fault,
    input wire logic in2_fault,
    input wire logic out1_sc_p,
    input wire logic out1_sc_m,
    input wire logic out1_vg_p,
    input wire logic out1_vg_m,
    input wire logic out2_sc_p,
    input wire logic out2_sc_m,
    input wire logic out2_vg_p,
    input wire logic out2_vg_m,
    input wire logic reg_short
);
    import fisr_pkg::*;

    fisr_byte_t hs_latch_q, hs_latch_d;
    fisr_byte_t mon_latch_q, mon_latch_d;
    fisr_byte_t clk_latch_q, clk_latch_d;
    fisr_byte_t clk_live_q, clk_live_d;
    fisr_byte_t ch_live_q, ch_live_d;
    fisr_byte_t out1_live_q, out1_live_d;
    fisr_byte_t out2_live_q, out2_live_d;
    fisr_byte_t rd_data_q, rd_data_d;
    fisr_byte_t hs_set, mon_set, clk_set;

    // Set wins over the read clear so an event in the read cycle survives
    function automatic fisr_byte_t latch_next(input fisr_byte_t cur, input fisr_byte_t set,
                                              input logic clr);
        latch_next = (clr ? 8'h00 : cur) | set;
    endfunction

    always_comb begin
        hs_set = 8'h00;
        mon_set = 8'h00;
        clk_set = 8'h00;
        hs_set[`FISR_BIT_HS_INSERT] = hs_insert;
        hs_set[`FISR_BIT_HS_REMOVE] = hs_remove;
        hs_set[`FISR_BIT_HS_HOOK] = hs_hook;
        mon_set[`FISR_BIT_THRESH_HIGH] = thresh_high;
        mon_set[`FISR_BIT_THRESH_LOW] = thresh_low;
        mon_set[`FISR_BIT_VOICE_UP] = voice_up;
        mon_set[`FISR_BIT_VOICE_DOWN] = voice_down;
        clk_set[`FISR_BIT_CLK_ERR] = clk_err;
        hs_latch_d = latch_next(hs_latch_q, hs_set,
                                rd_en && rd_addr == `FISR_ADDR_HS_LATCH);
        mon_latch_d = latch_next(mon_latch_q, mon_set,
                                 rd_en && rd_addr == `FISR_ADDR_MON_LATCH);
        clk_latch_d = latch_next(clk_latch_q, clk_set,
                                 rd_en && rd_addr == `FISR_ADDR_CLK_LATCH);
    end

    always_comb begin
        clk_live_d = 8'h00;
        ch_live_d = 8'h00;
        out1_live_d = 8'h00;
        out2_live_d = 8'h00;
        clk_live_d[`FISR_BIT_CLK_ERR] = clk_err;
        clk_live_d[`FISR_BIT_PLL_LOCK] = pll_lock;
        ch_live_d[`FISR_BIT_IN1] = in1_fault;
        ch_live_d[`FISR_BIT_IN2] = in2_fault;
        ch_live_d[`FISR_BIT_OUT1] = out1_sc_p | out1_sc_m | out1_vg_p | out1_vg_m;
        ch_live_d[`FISR_BIT_OUT2] = out2_sc_p | out2_sc_m | out2_vg_p | out2_vg_m | reg_short;
        out1_live_d[`FISR_BIT_SC_P] = out1_sc_p;
        out1_live_d[`FISR_BIT_SC_M] = out1_sc_m;
        out1_live_d[`FISR_BIT_VG_P] = out1_vg_p;
        out1_live_d[`FISR_BIT_VG_M] = out1_vg_m;
        out2_live_d[`FISR_BIT_SC_P] = out2_sc_p;
        out2_live_d[`FISR_BIT_SC_M] = out2_sc_m;
        out2_live_d[`FISR_BIT_VG_P] = out2_vg_p;
        out2_live_d[`FISR_BIT_VG_M] = out2_vg_m;
        out2_live_d[`FISR_BIT_REG_SHORT] = reg_short;
    end

    // Read data is the registered value before any clear of this cycle
    always_comb begin
        rd_data_d = rd_data_q;
        if (rd_en) begin
            unique case (rd_addr)
                `FISR_ADDR_CLK_LATCH: rd_data_d = clk_latch_q;
                `FISR_ADDR_HS_LATCH: rd_data_d = hs_latch_q;
                `FISR_ADDR_MON_LATCH: rd_data_d = mon_latch_q;
                `FISR_ADDR_CLK_LIVE: rd_data_d = clk_live_q;
                `FISR_ADDR_CH_LIVE: rd_data_d = ch_live_q;
                `FISR_ADDR_OUT1_LIVE: rd_data_d = out1_live_q;
                `FISR_ADDR_OUT2_LIVE: rd_data_d = out2_live_q;
                `FISR_ADDR_HS_LIVE: rd_data_d = 8'h00;
                // The whole live headset register lies outside this block and reads zero here
                default: rd_data_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hs_latch_q <= `FISR_RESET_VAL;
            mon_latch_q <= `FISR_RESET_VAL;
            clk_latch_q <= `FISR_RESET_VAL;
            clk_live_q <= `FISR_RESET_VAL;
            ch_live_q <= `FISR_RESET_VAL;
            out1_live_q <= `FISR_RESET_VAL;
            out2_live_q <= `FISR_RESET_VAL;
            rd_data_q <= `FISR_RESET_VAL;
        end else begin
            hs_latch_q <= hs_latch_d;
            mon_latch_q <= mon_latch_d;
            clk_latch_q <= clk_latch_d;
            clk_live_q <= clk_live_d;
            ch_live_q <= ch_live_d;
            out1_live_q <= out1_live_d;
            out2_live_q <= out2_live_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

    property p_hs_insert_latch;
        @(posedge clk) disable iff (srst)
        hs_insert |=> hs_latch_q[`FISR_BIT_HS_INSERT];
    endproperty
    a_hs_insert_latch: assert property (p_hs_insert_latch)
        else $error("insert not latched");

    property p_hs_remove_hold;
        @(posedge clk) disable iff (srst)
        hs_latch_q[`FISR_BIT_HS_REMOVE] && !(rd_en && rd_addr == `FISR_ADDR_HS_LATCH)
        |=> hs_latch_q[`FISR_BIT_HS_REMOVE];
    endproperty
    a_hs_remove_hold: assert property (p_hs_remove_hold)
        else $error("remove bit dropped");

    property p_read_clear;
        @(posedge clk) disable iff (srst)
        rd_en && rd_addr == `FISR_ADDR_MON_LATCH && !thresh_high
        |=> !mon_latch_q[`FISR_BIT_THRESH_HIGH];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read did not clear");

    property p_read_data;
        @(posedge clk) disable iff (srst)
        rd_en && rd_addr == `FISR_ADDR_HS_LATCH |=> rd_data == $past(hs_latch_q);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("latched read value wrong");

    property p_voice_up;
        @(posedge clk) disable iff (srst)
        voice_up |=> mon_latch_q[`FISR_BIT_VOICE_UP];
    endproperty
    a_voice_up: assert property (p_voice_up)
        else $error("voice up not latched");

    property p_clk_live;
        @(posedge clk) disable iff (srst)
        ##1 clk_live_q[`FISR_BIT_CLK_ERR] == $past(clk_err);
    endproperty
    a_clk_live: assert property (p_clk_live)
        else $error("clock error live wrong");

    property p_out_summary;
        @(posedge clk) disable iff (srst)
        out1_sc_p |=> ch_live_q[`FISR_BIT_OUT1];
    endproperty
    a_out_summary: assert property (p_out_summary)
        else $error("output summary missing");

    property p_reg_short;
        @(posedge clk) disable iff (srst)
        ##1 out2_live_q[`FISR_BIT_REG_SHORT] == $past(reg_short);
    endproperty
    a_reg_short: assert property (p_reg_short)
        else $error("regulator short wrong");

    property p_reserved;
        @(posedge clk) disable iff (srst)
        ##1 hs_latch_q[7:4] == 4'h0 && mon_latch_q[3:0] == 4'h0 && out2_live_q[3:1] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    property p_clk_latch;
        @(posedge clk) disable iff (srst)
        clk_err |=> clk_latch_q[`FISR_BIT_CLK_ERR];
    endproperty
    a_clk_latch: assert property (p_clk_latch)
        else $error("clock error not latched");

    property p_hs_remove_set;
        @(posedge clk) disable iff (srst)
        hs_remove |=> hs_latch_q[`FISR_BIT_HS_REMOVE];
    endproperty
    a_hs_remove_set: assert property (p_hs_remove_set)
        else $error("remove not latched");

    property p_hs_hook_set;
        @(posedge clk) disable iff (srst)
        hs_hook |=> hs_latch_q[`FISR_BIT_HS_HOOK];
    endproperty
    a_hs_hook_set: assert property (p_hs_hook_set)
        else $error("hook not latched");

    property p_thresh_high_set;
        @(posedge clk) disable iff (srst)
        thresh_high |=> mon_latch_q[`FISR_BIT_THRESH_HIGH];
    endproperty
    a_thresh_high_set: assert property (p_thresh_high_set)
        else $error("upper threshold not latched");

    property p_thresh_low_set;
        @(posedge clk) disable iff (srst)
        thresh_low |=> mon_latch_q[`FISR_BIT_THRESH_LOW];
    endproperty
    a_thresh_low_set: assert property (p_thresh_low_set)
        else $error("lower threshold not latched");

    property p_voice_down;
        @(posedge clk) disable iff (srst)
        voice_down |=> mon_latch_q[`FISR_BIT_VOICE_DOWN];
    endproperty
    a_voice_down: assert property (p_voice_down)
        else $error("voice down not latched");

    property p_pll_live;
        @(posedge clk) disable iff (srst)
        ##1 clk_live_q[`FISR_BIT_PLL_LOCK] == $past(pll_lock);
    endproperty
    a_pll_live: assert property (p_pll_live)
        else $error("lock live wrong");

    property p_in1_live;
        @(posedge clk) disable iff (srst)
        ##1 ch_live_q[`FISR_BIT_IN1] == $past(in1_fault);
    endproperty
    a_in1_live: assert property (p_in1_live)
        else $error("input 1 summary wrong");

    property p_in2_live;
        @(posedge clk) disable iff (srst)
        ##1 ch_live_q[`FISR_BIT_IN2] == $past(in2_fault);
    endproperty
    a_in2_live: assert property (p_in2_live)
        else $error("input 2 summary wrong");
endmodule // fisr_status

// *** test/tb_top.sv ***
// Self-checking bench for the fault and interrupt status readback block
`timescale 1ns/1ps

module tb_top;
    import fisr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rd_en = 1'b0;
    fisr_addr_t rd_addr = 8'h00;
    fisr_byte_t rd_data;
    logic [19:0] src = 20'h00000;
    fisr_byte_t hs_l, mon_l, ck_l, ckv, chv, o1, o2, exp_q;
    fisr_byte_t amap [8] = '{8'h34, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h41, 8'h42};
    int miscompares = 0;
    int checks_done = 0;
    logic go = 1'b0;

    always #50 clk = ~clk;

    fisr_status dut_u (
        .clk(clk), .srst(srst), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .hs_insert(src[0]), .hs_remove(src[1]), .hs_hook(src[2]),
        .thresh_high(src[3]), .thresh_low(src[4]), .voice_up(src[5]), .voice_down(src[6]),
        .clk_err(src[7]), .pll_lock(src[8]), .in1_fault(src[9]), .in2_fault(src[10]),
        .out1_sc_p(src[11]), .out1_sc_m(src[12]), .out1_vg_p(src[13]), .out1_vg_m(src[14]),
        .out2_sc_p(src[15]), .out2_sc_m(src[16]), .out2_vg_p(src[17]), .out2_vg_m(src[18]),
        .reg_short(src[19])
    );

    // Reference model, one step per rising edge; read mux sees pre-edge state
    always @(posedge clk) begin
        if (srst) begin
            {hs_l, mon_l, ck_l, ckv, chv, o1, o2, exp_q} = '0;
        end else begin
            if (rd_en) begin
                case (rd_addr)
                    8'h34: exp_q = ck_l;
                    8'h3A: exp_q = hs_l;
                    8'h3B: exp_q = mon_l;
                    8'h3C: exp_q = ckv;
                    8'h3D: exp_q = chv;
                    8'h40: exp_q = o1;
                    8'h41: exp_q = o2;
                    default: exp_q = 8'h00;
                endcase
                if (rd_addr == 8'h34) ck_l = 8'h00;
                if (rd_addr == 8'h3A) hs_l = 8'h00;
                if (rd_addr == 8'h3B) mon_l = 8'h00;
            end
            hs_l = hs_l | {4'h0, src[0], src[1], src[2], 1'b0};
            mon_l = mon_l | {src[3], src[4], src[5], src[6], 4'h0};
            ck_l = ck_l | {src[7], 7'h00};
            ckv = {src[7], src[8], 6'h00};
            chv = {src[9], src[10], |src[14:11], |src[19:15], 4'h0};
            o1 = {src[11], src[12], src[13], src[14], 4'h0};
            o2 = {src[15], src[16], src[17], src[18], 3'h0, src[19]};
        end
    end

    task automatic chk(input fisr_byte_t seen, input fisr_byte_t want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t ns: read data %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Read data holds between reads, so every cycle is a valid comparison point
    always @(negedge clk) begin
        if (go) begin
            chk(rd_data, exp_q);
        end
    end

    // Leaves the strobe high so two sweeps can follow back to back
    task automatic rd_all();
        for (int k = 0; k < 8; k++) begin
            rd_en = 1'b1;
            rd_addr = amap[k];
            @(negedge clk);
        end
    endtask

    task automatic idle(input int n);
        rd_en = 1'b0;
        repeat (n) @(negedge clk);
    endtask

    initial begin
        void'($urandom(65));
        repeat (20) @(negedge clk);
        srst = 1'b0;
        go = 1'b1;
        rd_all();
        idle(1);
        // Walk each source alone: live while held, latched after it goes away
        for (int i = 0; i < 20; i++) begin
            src = 20'h00001 << i;
            idle(2);
            rd_all();
            src = 20'h00000;
            idle(3);
            rd_all();
            rd_all();
            idle(1);
        end
        // Random traffic with sparse events, including unmapped addresses
        for (int n = 0; n < 600; n++) begin
            src = 20'($urandom & $urandom & $urandom);
            rd_en = 1'($urandom);
            rd_addr = ($urandom_range(3) == 0) ? 8'($urandom) : amap[$urandom_range(7)];
            @(negedge clk);
            if (n == 300) begin
                src = 20'h00000;
                srst = 1'b1;
                idle(3);
                srst = 1'b0;
                rd_all();
            end
        end
        idle(2);
        finish_test();
    end

    initial begin
        #(5000 * 100);
        miscompares++;
        finish_test();
    end
endmodule // tb_top
